// ---- logic/pmr_pkg.sv ----
// Package: power-mode and reset sequencer constants and carriers
package pmr_pkg;

    // Register offsets (word index = byte address on the plain port)
    localparam logic [3:0] PMR_OFS_CTRL   = 4'h0;
    localparam logic [3:0] PMR_OFS_TOCFG  = 4'h1;
    localparam logic [3:0] PMR_OFS_PWRCFG = 4'h2;
    localparam logic [3:0] PMR_OFS_FAULT  = 4'h3;
    localparam logic [3:0] PMR_OFS_STATUS = 4'h4;

    // Control register bits (self clearing)
    localparam int PMR_CTRL_OFF_BIT   = 0;
    localparam int PMR_CTRL_LOWP_BIT  = 1;
    localparam int PMR_CTRL_SRST_BIT  = 2;

    // Timeout configuration: [0] enable, [1] 1=shutdown 0=sleep, [4:2] duration code
    localparam int PMR_TO_EN_BIT      = 0;
    localparam int PMR_TO_OFF_BIT     = 1;
    localparam int PMR_TO_DUR_LSB     = 2;
    // Power transition configuration: [2:0] low-power duration code, 0 = disabled, [3] off on balance done
    localparam int PMR_PT_DUR_LSB     = 0;
    localparam int PMR_PT_BALOFF_BIT  = 3;

    // Fault register bits (write 1 to clear)
    localparam int PMR_F_DIGITAL_RESET_FLAG_BIT     = 0;
    localparam int PMR_F_UPPER_BIT    = 1;
    localparam int PMR_F_UCLR_BIT     = 2;
    localparam int PMR_F_STOP_BIT     = 3;

    localparam logic [7:0] PMR_TOCFG_RST  = 8'h00;
    localparam logic [7:0] PMR_PWRCFG_RST = 8'h00;

    // Timing: the base tick and the restart interval
    localparam int CLK_PERIOD_NS           = 10;
    localparam int PMR_TICK_US             = 1000;
    localparam int PMR_TICK_CYC            = (PMR_TICK_US * 1000) / CLK_PERIOD_NS;
    localparam int HARD_RESTART_INTERVAL_US = 100;
    localparam int HARD_RESTART_CYC        = (HARD_RESTART_INTERVAL_US * 1000) / CLK_PERIOD_NS;

    // Power modes, one-hot
    typedef enum logic [4:0] {
        PMR_POR      = 5'h01,
        PMR_OFF      = 5'h02,
        PMR_LOWP     = 5'h04,
        PMR_ACTIVE   = 5'h08,
        PMR_RESTART  = 5'h10
    } pmr_mode_t;

    // Ping and tone events, one-cycle pulses from the detectors
    typedef struct packed {
        logic wake;
        logic resume_without_reset_signal;
        logic off;
        logic hard_restart_signal;
        logic uart_clear;
    } pmr_evt_t;

    // Analog and monitor events
    typedef struct packed {
        logic supply_ok;
        logic analog_supply_uv;
        logic digital_supply_uv;
        logic osc_watchdog;
        logic thermal_shut;
        logic balance_done;
        logic link_valid;
    } pmr_mon_t;

    // Function enables by mode
    typedef struct packed {
        logic adc_en;
        logic uart_en;
        logic vertical_en;
        logic spi_en;
        logic otp_prog_en;
        logic protect_en;
        logic balance_en;
        logic fault_sig_en;
        logic thermal_en;
        logic supplies_on;
        logic bandgap_on;
    } pmr_func_t;

endpackage

// ---- logic/pmr_tick_timer.sv ----
// Tick-based idle timer with coded durations
`timescale 1ns/100ps
module pmr_tick_timer
    import pmr_pkg::*;
#(
    parameter int TICK_CYC = PMR_TICK_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] dur_code,
    // Result
    output logic            expired
);
    typedef struct packed {
        logic [31:0] pre;
        logic [11:0] ticks;
        logic        done;
    } pmr_tmr_t;

    pmr_tmr_t s_reg, s_next;
    logic [11:0] limit;

    // Durations grow by doubling: code n gives 2^(n+4) ticks
    assign limit   = 12'h010 << dur_code;
    assign expired = s_reg.done;

    always_comb begin
        s_next = s_reg;
        if (!run || restart) begin
            s_next = '0;
        end else if (!s_reg.done) begin
            if (s_reg.pre == 32'(TICK_CYC - 1)) begin
                s_next.pre   = '0;
                s_next.ticks = s_reg.ticks + 12'h001;
                if (s_reg.ticks + 12'h001 >= limit) begin
                    s_next.done = 1'b1;
                end
            end else begin
                s_next.pre = s_reg.pre + 32'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // pmr_tick_timer

// ---- logic/pmr_regs.sv ----
// Register file: control, configuration and fault flags
`timescale 1ns/100ps
module pmr_regs
    import pmr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Bus
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    // Block side
    input  wire logic       dflt,
    input  wire logic [3:0] fault_set,
    input  wire logic [4:0] mode,
    output logic [2:0]      ctrl_pulse,
    output logic [7:0]      tocfg,
    output logic [7:0]      pwrcfg,
    output logic [3:0]      faults
);
    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] tocfg;
        logic [7:0] pwrcfg;
        logic [3:0] faults;
    } pmr_rf_t;

    pmr_rf_t s_reg, s_next;
    logic    wr_ctrl;

    assign wr_ctrl    = wr && addr == PMR_OFS_CTRL;
    assign ctrl_pulse = wr_ctrl ? wdata[2:0] : 3'h0;
    assign tocfg      = s_reg.tocfg;
    assign pwrcfg     = s_reg.pwrcfg;
    assign faults     = s_reg.faults;
    assign rdata      = s_reg.rdata;

    always_comb begin
        s_next       = s_reg;
        s_next.rdata = 8'h00;
        if (wr && addr == PMR_OFS_TOCFG) begin
            s_next.tocfg = wdata;
        end
        if (wr && addr == PMR_OFS_PWRCFG) begin
            s_next.pwrcfg = wdata;
        end
        if (wr && addr == PMR_OFS_FAULT) begin
            s_next.faults = s_reg.faults & ~wdata[3:0];
        end
        // Hardware set wins over a software clear in the same cycle
        s_next.faults = s_next.faults | fault_set;
        if (rd) begin
            unique case (addr)
                PMR_OFS_TOCFG:  s_next.rdata = s_reg.tocfg;
                PMR_OFS_PWRCFG: s_next.rdata = s_reg.pwrcfg;
                PMR_OFS_FAULT:  s_next.rdata = {4'h0, s_reg.faults};
                PMR_OFS_STATUS: s_next.rdata = {3'h0, mode};
                default:        s_next.rdata = 8'h00;
            endcase
        end
        // Defaulting keeps the flags that the same reset raises
        if (dflt) begin
            s_next.tocfg  = PMR_TOCFG_RST;
            s_next.pwrcfg = PMR_PWRCFG_RST;
            s_next.faults = fault_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '{rdata: 8'h00, tocfg: PMR_TOCFG_RST, pwrcfg: PMR_PWRCFG_RST, faults: 4'h0};
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // pmr_regs

// ---- logic/pmr_top.sv ----
// Power-mode state machine and reset sequencing
// Behaviour
// - Low supply is POR; rise enters off
// - Off mode: only wake leads to active
// - Off wake sets reset, upper, clear flags; here upper only when not top, clear only on base
// - Off command bit enters off mode
// - Link idle timeout can force off
// - Low-power duration expiry forces off
// - Balance done can force off
// - Overtemperature shuts down in low-power, active
// - Off ping enters off without link
// - Restart ping: bandgap only, then off
// - Functions enabled per mode as listed
// - Wake resets; resume ping does not
// - Low-power only from active, by command or idle timeout
// - Link idle timeout can force low-power
// - Off to active reloads defaults and OTP
// - Low-power wake is a digital reset
// - Resume ping resets UART, sets clear flag
// - Wake, soft reset, UV, watchdog: full reset
// - Resume in active or clear: stop flag
// - UART-only resets act on base only
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module pmr_top
    import pmr_pkg::*;
#(
    parameter int HARD_RESTART_CYCLES = HARD_RESTART_CYC,
    parameter int TICK_CYCLES         = PMR_TICK_CYC
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    // Register port
    input  wire logic [3:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic [7:0]             RDATA,
    // Chain position straps
    input  wire logic              IS_BASE,
    input  wire logic              IS_TOP,
    // Detected pings, tones and monitors
    input  wire pmr_pkg::pmr_evt_t EVT,
    input  wire pmr_pkg::pmr_mon_t MON,
    // Mode and reset outputs
    output pmr_pkg::pmr_mode_t     MODE,
    output pmr_pkg::pmr_func_t     FUNC,
    output logic                   DIGITAL_RESET,
    output logic                   OTP_RELOAD,
    output logic                   UART_RESET
);
    import pmr_pkg::*;

    typedef struct packed {
        pmr_mode_t  mode;
        logic [31:0] rst_cnt;
        logic       digital_reset_flag;
        logic       uclr;
        pmr_func_t  func;
    } pmr_st_t;

    pmr_st_t    s_reg, s_next;
    logic [2:0] ctrl_pulse;
    logic [7:0] tocfg;
    logic [7:0] pwrcfg;
    logic [3:0] faults;
    logic [3:0] fault_set;
    logic       dflt;
    logic       idle_exp;
    logic       lowp_exp;
    logic       link_run;
    logic       lowp_run;
    logic       in_active;
    logic       in_lowp;
    logic       in_off;
    logic       full_reset;
    logic       uart_only;
    logic       want_off;
    logic       want_lowp;

    assign in_active = s_reg.mode == PMR_ACTIVE;
    assign in_lowp   = s_reg.mode == PMR_LOWP;
    assign in_off    = s_reg.mode == PMR_OFF;

    // Register writes are only accepted in active mode; reads are served in every mode
    pmr_regs u_regs (
        .clk        (CLK),
        .rst        (SYS_RST),
        .addr       (ADDR),
        .wdata      (WDATA),
        .wr         (WR && in_active),
        .rd         (RD),
        .rdata      (RDATA),
        .dflt       (dflt),
        .fault_set  (fault_set),
        .mode       (s_reg.mode),
        .ctrl_pulse (ctrl_pulse),
        .tocfg      (tocfg),
        .pwrcfg     (pwrcfg),
        .faults     (faults)
    );

    // Link idle timer runs in active only; any valid traffic restarts it
    assign link_run = in_active && tocfg[PMR_TO_EN_BIT];
    pmr_tick_timer #(.TICK_CYC(TICK_CYCLES)) u_idle (
        .clk      (CLK),
        .rst      (SYS_RST),
        .run      (link_run),
        .restart  (MON.link_valid || WR || RD),
        .dur_code (tocfg[PMR_TO_DUR_LSB +: 3]),
        .expired  (idle_exp)
    );

    // Low-power duration timer: code 0 disables it
    assign lowp_run = in_lowp && pwrcfg[PMR_PT_DUR_LSB +: 3] != 3'h0;
    pmr_tick_timer #(.TICK_CYC(TICK_CYCLES)) u_lowp (
        .clk      (CLK),
        .rst      (SYS_RST),
        .run      (lowp_run),
        .restart  (1'b0),
        .dur_code (pwrcfg[PMR_PT_DUR_LSB +: 3] - 3'h1),
        .expired  (lowp_exp)
    );

    // Full digital reset causes in active mode
    assign full_reset = in_active && (EVT.wake || ctrl_pulse[PMR_CTRL_SRST_BIT]
                        || MON.analog_supply_uv || MON.digital_supply_uv || MON.osc_watchdog);

    // UART-only reset: no effect on a stack device
    assign uart_only = IS_BASE && in_active && (EVT.resume_without_reset_signal || EVT.uart_clear);

    assign want_off = (in_active && (ctrl_pulse[PMR_CTRL_OFF_BIT]
                      || (idle_exp && tocfg[PMR_TO_OFF_BIT])
                      || (pwrcfg[PMR_PT_BALOFF_BIT] && MON.balance_done)))
                      || (in_lowp && (lowp_exp
                      || (pwrcfg[PMR_PT_BALOFF_BIT] && MON.balance_done)))
                      || ((in_active || in_lowp) && EVT.off);

    assign want_lowp = in_active && (ctrl_pulse[PMR_CTRL_LOWP_BIT]
                       || (idle_exp && !tocfg[PMR_TO_OFF_BIT]));

    // Flag sets for the register file, one cycle wide
    always_comb begin
        fault_set = 4'h0;
        dflt      = 1'b0;
        if (s_reg.digital_reset_flag) begin
            dflt = 1'b1;
            fault_set[PMR_F_DIGITAL_RESET_FLAG_BIT] = 1'b1;
            fault_set[PMR_F_UPPER_BIT] = !IS_TOP;
            fault_set[PMR_F_UCLR_BIT] = IS_BASE;
        end
        if (s_reg.uclr) begin
            fault_set[PMR_F_UCLR_BIT] = 1'b1;
        end
        if (uart_only) begin
            fault_set[PMR_F_UCLR_BIT] = 1'b1;
            fault_set[PMR_F_STOP_BIT] = 1'b1;
        end
    end

    // Mode machine; cause order fixes the priority
    always_comb begin
        s_next      = s_reg;
        s_next.digital_reset_flag = 1'b0;
        s_next.uclr = 1'b0;
        unique case (s_reg.mode)
            PMR_POR: begin
                if (MON.supply_ok) begin
                    s_next.mode = PMR_OFF;
                end
            end
            PMR_RESTART: begin
                // Count runs from the restart event; only a supply loss is heard besides
                if (s_reg.rst_cnt == 32'(HARD_RESTART_CYCLES - 1)) begin
                    s_next.mode = PMR_OFF;
                end else begin
                    s_next.rst_cnt = s_reg.rst_cnt + 32'h1;
                end
            end
            PMR_OFF: begin
                if (EVT.wake) begin
                    s_next.mode = PMR_ACTIVE;
                    s_next.digital_reset_flag = 1'b1;
                end
            end
            PMR_LOWP, PMR_ACTIVE: begin
                if (EVT.hard_restart_signal) begin
                    s_next.mode    = PMR_RESTART;
                    s_next.rst_cnt = '0;
                end else if (MON.thermal_shut) begin
                    s_next.mode = PMR_OFF;
                end else if (want_off) begin
                    s_next.mode = PMR_OFF;
                end else if (want_lowp) begin
                    s_next.mode = PMR_LOWP;
                end else if (in_lowp && EVT.wake) begin
                    s_next.mode = PMR_ACTIVE;
                    s_next.digital_reset_flag = 1'b1;
                end else if (in_lowp && EVT.resume_without_reset_signal) begin
                    s_next.mode = PMR_ACTIVE;
                    s_next.uclr = IS_BASE;
                end else if (full_reset) begin
                    s_next.digital_reset_flag = 1'b1;
                end
            end
            default: begin
                s_next.mode = PMR_OFF;
            end
        endcase
        // Supply loss overrides every mode
        if (!MON.supply_ok) begin
            s_next.mode = PMR_POR;
            s_next.digital_reset_flag = 1'b0;
            s_next.uclr = 1'b0;
        end

        // Function enables follow the next mode so they change with it
        s_next.func             = '0;
        s_next.func.bandgap_on  = s_next.mode != PMR_POR;
        if (s_next.mode == PMR_ACTIVE) begin
            s_next.func = '{adc_en: 1'b1, uart_en: IS_BASE, vertical_en: 1'b1, spi_en: 1'b1,
                            otp_prog_en: 1'b1, protect_en: 1'b1, balance_en: 1'b1, fault_sig_en: 1'b1,
                            thermal_en: 1'b1, supplies_on: 1'b1, bandgap_on: 1'b1};
        end else if (s_next.mode == PMR_LOWP) begin
            // Protectors and balancing stay enabled in low-power, as in active
            s_next.func.protect_en   = 1'b1;
            s_next.func.balance_en   = 1'b1;
            s_next.func.fault_sig_en = 1'b1;
            s_next.func.thermal_en   = 1'b1;
            s_next.func.supplies_on  = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_reg <= '{mode: PMR_POR, rst_cnt: 32'h0, digital_reset_flag: 1'b0, uclr: 1'b0, func: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign MODE          = s_reg.mode;
    assign FUNC          = s_reg.func;
    assign DIGITAL_RESET = s_reg.digital_reset_flag;
    assign OTP_RELOAD    = s_reg.digital_reset_flag;
    assign UART_RESET    = s_reg.digital_reset_flag || s_reg.uclr || uart_only;

endmodule // pmr_top

// ---- test/pmr_top_monitor.sv ----
// Port-level checks of the power-mode sequencer
`timescale 1ns/100ps
module pmr_top_monitor
    import pmr_pkg::*;
#(
    parameter int HARD_RESTART_CYCLES = HARD_RESTART_CYC
) (
    // Clock and reset
    input wire logic               CLK,
    input wire logic               SYS_RST,
    // Inputs watched
    input wire logic               IS_BASE,
    input wire pmr_pkg::pmr_evt_t  EVT,
    input wire pmr_pkg::pmr_mon_t  MON,
    // Outputs watched
    input wire pmr_pkg::pmr_mode_t MODE,
    input wire pmr_pkg::pmr_func_t FUNC,
    input wire logic               DIGITAL_RESET,
    input wire logic               OTP_RELOAD,
    input wire logic               UART_RESET
);
    int unsigned rcnt_reg;
    logic        run;
    logic        up;
    assign run = MODE == PMR_ACTIVE || MODE == PMR_LOWP;
    assign up  = MON.supply_ok && !EVT.hard_restart_signal;
    // Index of the current cycle inside a restart
    always_ff @(posedge CLK) begin
        rcnt_reg <= (MODE == PMR_RESTART && !SYS_RST) ? rcnt_reg + 1 : 0;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_off_only_wake: assert property (MODE == PMR_OFF && MON.supply_ok
        |=> MODE == ($past(EVT.wake) ? PMR_ACTIVE : PMR_OFF)) else $error("off mode left wrongly");
    a_wake_full_reset: assert property (MODE == PMR_OFF && EVT.wake && MON.supply_ok
        |=> DIGITAL_RESET && OTP_RELOAD && UART_RESET) else $error("wake from off without reset");
    a_restart_hold: assert property (MODE == PMR_RESTART |-> rcnt_reg < HARD_RESTART_CYCLES)
        else $error("restart too long");
    a_restart_exit: assert property (MODE == PMR_RESTART && rcnt_reg == HARD_RESTART_CYCLES - 1
        && MON.supply_ok |=> MODE == PMR_OFF) else $error("restart did not end in off");
    a_hard_first: assert property (run && EVT.hard_restart_signal && MON.supply_ok
        |=> MODE == PMR_RESTART) else $error("restart ping lost");
    a_thermal_off: assert property (run && MON.thermal_shut && up |=> MODE == PMR_OFF)
        else $error("thermal shutdown missed");
    a_off_ping: assert property (run && EVT.off && up |=> MODE == PMR_OFF)
        else $error("off ping missed");
    a_por_low: assert property (!MON.supply_ok |=> MODE == PMR_POR)
        else $error("low supply not por");
    a_lowp_source: assert property ($rose(MODE == PMR_LOWP) |-> $past(MODE) == PMR_ACTIVE)
        else $error("low power entered from wrong mode");
    a_func_gate: assert property (MODE != PMR_ACTIVE |-> !(FUNC.adc_en || FUNC.uart_en
        || FUNC.vertical_en || FUNC.spi_en || FUNC.otp_prog_en)) else $error("active-only function on");
    a_stack_uart: assert property (!IS_BASE && !DIGITAL_RESET |-> !UART_RESET)
        else $error("uart reset on stack device");
    a_reset_pair: assert property (OTP_RELOAD == DIGITAL_RESET && (!DIGITAL_RESET || UART_RESET))
        else $error("reset outputs disagree");
    a_resume_keep: assert property (MODE == PMR_LOWP && EVT.resume_without_reset_signal && up
        && !MON.thermal_shut && !EVT.off && !EVT.wake && !MON.balance_done
        |=> MODE == PMR_ACTIVE && !DIGITAL_RESET && UART_RESET == $past(IS_BASE)) else $error("resume wrong");
    c_wake: cover property (MODE == PMR_OFF && EVT.wake);
    c_restart: cover property (MODE == PMR_RESTART);
    c_resume: cover property (MODE == PMR_LOWP && EVT.resume_without_reset_signal);
endmodule // pmr_top_monitor

bind pmr_top pmr_top_monitor #(.HARD_RESTART_CYCLES(HARD_RESTART_CYCLES)) u_pmr_top_monitor (
    .CLK(CLK), .SYS_RST(SYS_RST), .IS_BASE(IS_BASE), .EVT(EVT), .MON(MON), .MODE(MODE), .FUNC(FUNC),
    .DIGITAL_RESET(DIGITAL_RESET), .OTP_RELOAD(OTP_RELOAD), .UART_RESET(UART_RESET));

// ---- test/pmr_host_model.sv ----
// Host model: register port master and ping sender
`timescale 1ns/100ps
module pmr_host_model
    import pmr_pkg::*;
(
    // Clock
    input  wire logic         clk,
    // Register port
    output logic [3:0]        addr,
    output logic [7:0]        wdata,
    output logic              wr,
    output logic              rd,
    // Pings and tones
    output pmr_pkg::pmr_evt_t evt
);
    logic [7:0] exp_q[$];
    initial begin
        addr  = 4'h0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        evt   = '0;
    end
    // One strobe cycle; for a read, d is the expected data
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        // Idle lines wander so nothing leans on a held value
        addr  <= ~a;
        wdata <= ~d;
    endtask
    // One-cycle ping, then a quiet cycle for flags to settle
    task automatic ping(input pmr_evt_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        @(posedge clk);
    endtask
endmodule // pmr_host_model

// ---- test/tb_pmr_top.sv ----
// Self-checking bench of the power-mode sequencer
`timescale 1ns/100ps
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin errors++; \
    $display("CHECK FAILED %0t read data mismatch", $time); end end
module tb_pmr_top;
    import pmr_pkg::*;
    localparam int       HR      = 5;
    localparam int       TK      = 4;
    localparam pmr_evt_t EV_WAKE = 5'h10;
    localparam pmr_evt_t EV_RES  = 5'h08;
    localparam pmr_evt_t EV_OFF  = 5'h04;
    localparam pmr_evt_t EV_HRD  = 5'h02;
    localparam pmr_evt_t EV_UCL  = 5'h01;
    logic       CLK;
    logic       SYS_RST;
    logic [3:0] ADDR;
    logic [7:0] WDATA;
    logic       WR;
    logic       RD;
    logic [7:0] RDATA;
    logic       IS_BASE;
    logic       IS_TOP;
    pmr_evt_t   EVT;
    pmr_mon_t   MON;
    pmr_mode_t  MODE;
    pmr_func_t  FUNC;
    logic       rd_d = 1'b0;
    int         errors = 0;
    int         samples_checked = 0;
    int         seed;
    logic [7:0] v;

    pmr_top #(.HARD_RESTART_CYCLES(HR), .TICK_CYCLES(TK)) u_pmr_top (
        .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .IS_BASE(IS_BASE), .IS_TOP(IS_TOP), .EVT(EVT), .MON(MON), .MODE(MODE), .FUNC(FUNC),
        .DIGITAL_RESET(), .OTP_RELOAD(), .UART_RESET());
    pmr_host_model u_pmr_host_model (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .evt(EVT));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // Read data stand only in the cycle after the strobe
    always @(posedge CLK) begin
        if (rd_d === 1'b1) `CHK(RDATA, u_pmr_host_model.exp_q.pop_front())
        rd_d <= RD;
    end

    task automatic w(input logic [3:0] a, input logic [7:0] d);
        u_pmr_host_model.xfer(1'b1, a, d);
    endtask
    task automatic r(input logic [3:0] a, input logic [7:0] x);
        u_pmr_host_model.xfer(1'b0, a, x);
    endtask
    task automatic p(input pmr_evt_t e);
        u_pmr_host_model.ping(e);
    endtask
    task automatic mp(input logic [6:0] m);
        @(posedge CLK);
        MON <= MON | m;
        @(posedge CLK);
        MON <= MON & ~m;
        @(posedge CLK);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge CLK);
        errors++;
        $display("CHECK FAILED %0t run did not finish", $time);
        finish_test();
    end

    initial begin
        seed    = 87543;
        IS_BASE = 1'b0;
        IS_TOP  = 1'b0;
        MON     = 7'h40;
        SYS_RST = 1'b1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        r(PMR_OFS_STATUS, 8'h02);
        r(PMR_OFS_TOCFG, PMR_TOCFG_RST);
        r(PMR_OFS_PWRCFG, PMR_PWRCFG_RST);
        r(4'(5 + {$random(seed)} % 11), 8'h00);
        w(PMR_OFS_CTRL, 8'h02);
        r(PMR_OFS_STATUS, 8'h02);
        // Stack, top and base positions in turn
        for (int k = 0; k < 3; k++) begin
            IS_BASE <= (k == 2);
            IS_TOP  <= (k == 1);
            w(PMR_OFS_CTRL, 8'h01);
            r(PMR_OFS_STATUS, 8'h02);
            p(EV_WAKE);
            r(PMR_OFS_STATUS, 8'h08);
            r(PMR_OFS_FAULT, 8'(1 + 2 * (k != 1) + 4 * (k == 2)));
            w(PMR_OFS_FAULT, 8'h0f);
            r(PMR_OFS_FAULT, 8'h00);
        end
        for (int k = 0; k < 3; k++) begin
            IS_BASE <= (k < 2);
            p(k == 1 ? EV_UCL : EV_RES);
            r(PMR_OFS_FAULT, k < 2 ? 8'h0c : 8'h00);
            w(PMR_OFS_FAULT, 8'h0f);
        end
        IS_BASE <= 1'b1;
        $display("test wake and uart done");
        v = 8'(1 + {$random(seed)} % 7);
        w(PMR_OFS_PWRCFG, v);
        w(PMR_OFS_CTRL, 8'h02);
        r(PMR_OFS_STATUS, 8'h04);
        w(PMR_OFS_CTRL, 8'h01);
        r(PMR_OFS_STATUS, 8'h04);
        p(EV_RES);
        r(PMR_OFS_STATUS, 8'h08);
        r(PMR_OFS_PWRCFG, v);
        r(PMR_OFS_FAULT, 8'h04);
        w(PMR_OFS_FAULT, 8'h0f);
        w(PMR_OFS_CTRL, 8'h02);
        p(EV_WAKE);
        r(PMR_OFS_STATUS, 8'h08);
        r(PMR_OFS_PWRCFG, 8'h00);
        $display("test low power done");
        // Code 0 or 1 expires after 16 ticks
        for (int k = 0; k < 3; k++) begin
            w(k == 0 ? PMR_OFS_PWRCFG : PMR_OFS_TOCFG, k == 1 ? 8'h03 : 8'h01);
            if (k == 0) w(PMR_OFS_CTRL, 8'h02);
            repeat (16 * TK + 20) @(posedge CLK);
            r(PMR_OFS_STATUS, k == 2 ? 8'h04 : 8'h02);
            p(EV_WAKE);
        end
        for (int k = 0; k < 4; k++) begin
            if (k == 0) w(PMR_OFS_PWRCFG, 8'h08);
            if (k == 2) w(PMR_OFS_CTRL, 8'h02);
            if (k == 3) p(EV_OFF);
            else mp(k == 0 ? 7'h02 : 7'h04);
            r(PMR_OFS_STATUS, 8'h02);
            p(EV_WAKE);
        end
        $display("test timed exits done");
        p(EV_HRD | EV_OFF | EV_WAKE);
        r(PMR_OFS_STATUS, 8'h10);
        repeat (HR) @(posedge CLK);
        r(PMR_OFS_STATUS, 8'h02);
        p(EV_WAKE);
        for (int k = 0; k < 5; k++) begin
            w(PMR_OFS_PWRCFG, 8'h05);
            if (k == 0) w(PMR_OFS_CTRL, 8'h04);
            else if (k == 4) p(EV_WAKE);
            else mp(7'h04 << k);
            r(PMR_OFS_PWRCFG, 8'h00);
        end
        MON.supply_ok <= 1'b0;
        r(PMR_OFS_STATUS, 8'h01);
        MON.supply_ok <= 1'b1;
        r(PMR_OFS_STATUS, 8'h02);
        $display("test resets done");
        repeat (3) @(posedge CLK);
        finish_test();
    end
endmodule // tb_pmr_top
